// >>> hdl/trig_port_pkg.sv
package trig_port_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W            = 4;
  localparam logic [3:0]  OFF_LEVELS        = 4'h0;
  localparam logic [3:0]  OFF_CONFIG        = 4'h4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned NUM_OUT           = 8;
  localparam int unsigned NUM_TRIG          = 5;
  localparam int unsigned NUM_STRETCH       = 4;
  localparam int unsigned COMBINED_BIT      = 4;
  localparam int unsigned PLAIN_LSB         = 5;
  localparam int unsigned CFG_POL_BIT       = 5;
  localparam int unsigned CFG_WIDTH_LSB     = 29;
  localparam int unsigned CFG_WIDTH_MSB     = 31;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  LEVELS_RST        = 8'h00;
  localparam logic [2:0]  WIDTH_RST         = 3'h0;
  localparam logic        POL_RST           = 1'b0;
  localparam logic [4:0]  SEL_RST           = 5'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned TICK_NS           = 1000;
  localparam int unsigned TICK_CYCLES       = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_CODE0_US       = 1000;
  localparam int unsigned PW_CODE1_US       = 200;
  localparam int unsigned PW_CODE2_US       = 20;
  localparam int unsigned PW_CODE3_US       = 5;
  localparam int unsigned PW_CNT_W          = 11;

  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // top code bit set selects toggle instead of a pulse
  function automatic logic is_toggle(input logic [2:0] code);
    return code[2];
  endfunction : is_toggle

  function automatic logic [PW_CNT_W-1:0] width_us(input logic [2:0] code);
    unique case (code[1:0])
      2'h0:    return PW_CNT_W'(PW_CODE0_US);
      2'h1:    return PW_CNT_W'(PW_CODE1_US);
      2'h2:    return PW_CNT_W'(PW_CODE2_US);
      default: return PW_CNT_W'(PW_CODE3_US);
    endcase
  endfunction : width_us

endpackage : trig_port_pkg

// >>> hdl/pulse_ctrl_if.sv
`timescale 1ns/100ps
interface pulse_ctrl_if;
  logic       tick;
  logic [2:0] width_code;

  modport timebase (output tick);
  modport ctrl     (output width_code);
  modport chan     (input tick, input width_code);
endinterface : pulse_ctrl_if

// >>> hdl/us_tick_gen.sv
`timescale 1ns/100ps
module us_tick_gen
  import trig_port_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  pulse_ctrl_if.timebase  tb
);

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic       next_tick;

  // ----------------------------------------------------------------
  // one-microsecond enable
  // ----------------------------------------------------------------
  // system clock timing
  always_comb begin
    next_tick = (cnt == 7'(TICK_CYCLES - 1));
    next_cnt  = next_tick ? 7'h00 : cnt + 7'h01;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt     <= 7'h00;
      tb.tick <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      tb.tick <= next_tick;
    end
  end

endmodule : us_tick_gen

// >>> hdl/pulse_channel.sv
`timescale 1ns/100ps
module pulse_channel
  import trig_port_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  pulse_ctrl_if.chan      cfg,
  input  wire logic       trig,
  output logic            level
);

  logic [PW_CNT_W-1:0] cnt;
  logic [PW_CNT_W-1:0] next_cnt;
  logic                next_level;

  // ----------------------------------------------------------------
  // pulse stretcher / toggler
  // ----------------------------------------------------------------
  // one extra tick is loaded so the pulse is never shorter than its code,
  // at the price of up to one microsecond of extra length
  always_comb begin
    next_cnt   = cnt;
    next_level = level;
    if (is_toggle(cfg.width_code)) begin
      next_cnt = '0;
      if (trig) begin
        next_level = !level;
      end
    end else begin
      if (trig) begin
        next_cnt = width_us(cfg.width_code) + PW_CNT_W'(1);
      end else if (cfg.tick && cnt != '0) begin
        next_cnt = cnt - PW_CNT_W'(1);
      end
      next_level = (next_cnt != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt   <= '0;
      level <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      level <= next_level;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pulse_5us;
    @(posedge clk) disable iff (!resetn)
      (trig && cfg.width_code == 3'h3) |=> level [*8] ##[1:760] (!level || trig);
  endproperty
  a_pulse_5us: assert property (p_pulse_5us) else $error("5 us pulse length wrong");

  property p_toggle;
    @(posedge clk) disable iff (!resetn)
      (trig && cfg.width_code[2]) |=> (level != $past(level));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not invert");

endmodule : pulse_channel

// >>> hdl/digital_output_trigger_port.sv
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module digital_output_trigger_port
  import trig_port_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [NUM_TRIG-1:0] trig_event,
  output logic [NUM_OUT-1:0]       out_gate
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                   aw_held;
  logic [ADDR_W-1:0]      aw_addr;
  logic                   w_held;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   next_aw_held;
  logic [ADDR_W-1:0]      next_aw_addr;
  logic                   next_w_held;
  logic [31:0]            next_w_data;
  logic [3:0]             next_w_strb;
  logic                   next_awready;
  logic                   next_wready;
  logic                   next_bvalid;
  logic [1:0]             next_bresp;
  logic                   next_arready;
  logic                   next_rvalid;
  logic [31:0]            next_rdata;
  logic [1:0]             next_rresp;
  logic                   write_fire;

  logic [7:0]             output_level_register;
  logic [2:0]             width_code;
  logic                   polarity;
  logic [4:0]             trig_select;
  logic [7:0]             next_levels;
  logic [2:0]             next_width;
  logic                   next_polarity;
  logic [4:0]             next_select;
  logic [31:0]            cfg_word;
  logic [31:0]            cfg_merged;

  logic [NUM_STRETCH-1:0] chan_level;
  logic [NUM_OUT-1:0]     next_out;

  pulse_ctrl_if           pctl ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_LEVELS) || (a == OFF_CONFIG);
  endfunction : addr_mapped

  // reserved bits 28..6 read as zero
  always_comb begin
    cfg_word                                = 32'h0000_0000;
    cfg_word[CFG_WIDTH_MSB:CFG_WIDTH_LSB]   = width_code;
    cfg_word[CFG_POL_BIT]                   = polarity;
    cfg_word[NUM_TRIG-1:0]                  = trig_select;
  end

  assign cfg_merged = merge_strb(cfg_word, w_data, w_strb);

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are caught independently; the write is applied one
  // cycle after both are held and no response is still pending
  always_comb begin
    write_fire   = aw_held && w_held && !s_axi_bvalid;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (write_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      w_held        <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    next_levels   = output_level_register;
    next_width    = width_code;
    next_polarity = polarity;
    next_select   = trig_select;
    if (write_fire && aw_addr == OFF_LEVELS) begin
      next_levels = 8'(merge_strb({24'h00_0000, output_level_register}, w_data, w_strb));
    end
    if (write_fire && aw_addr == OFF_CONFIG) begin
      next_width    = cfg_merged[CFG_WIDTH_MSB:CFG_WIDTH_LSB];
      next_polarity = cfg_merged[CFG_POL_BIT];
      next_select   = cfg_merged[NUM_TRIG-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      output_level_register <= LEVELS_RST;
      width_code            <= WIDTH_RST;
      polarity              <= POL_RST;
      trig_select           <= SEL_RST;
    end else begin
      output_level_register <= next_levels;
      width_code            <= next_width;
      polarity              <= next_polarity;
      trig_select           <= next_select;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_arready = s_axi_arready;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid  = 1'b1;
      next_arready = 1'b0;
      next_rresp   = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFF_LEVELS: next_rdata = {24'h00_0000, output_level_register};
        OFF_CONFIG: next_rdata = cfg_word;
        default:    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_arready <= next_arready;
    end
  end

  // ----------------------------------------------------------------
  // trigger channels
  // ----------------------------------------------------------------
  // shared width code
  assign pctl.width_code = width_code;

  us_tick_gen u_tick (
    .clk    (clk),
    .resetn (resetn),
    .tb     (pctl.timebase)
  );

  for (genvar n = 0; n < NUM_STRETCH; n++) begin : g_chan
    pulse_channel u_chan (
      .clk    (clk),
      .resetn (resetn),
      .cfg    (pctl.chan),
      .trig   (trig_event[n]),
      .level  (chan_level[n])
    );
  end

  // ----------------------------------------------------------------
  // output mux
  // ----------------------------------------------------------------
  // polarity touches only software levels; trigger pulses always turn the
  // transistor on
  always_comb begin
    next_out = output_level_register ^ {NUM_OUT{polarity}};
    for (int n = 0; n < NUM_STRETCH; n++) begin
      if (trig_select[n]) begin
        next_out[n] = chan_level[n];
      end
    end
    if (trig_select[COMBINED_BIT]) begin
      next_out[COMBINED_BIT] = trig_event[COMBINED_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_gate <= '0;
    end else begin
      out_gate <= next_out;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reset_off;
    @(posedge clk) $past(!resetn) && resetn |-> (out_gate == '0);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("outputs not off after reset");

  property p_upper_plain;
    @(posedge clk) disable iff (!resetn)
      ##1 out_gate[7:PLAIN_LSB] == ($past(output_level_register[7:PLAIN_LSB]) ^ {3{$past(polarity)}});
  endproperty
  a_upper_plain: assert property (p_upper_plain) else $error("upper bits not plain levels");

  property p_pol_off;
    @(posedge clk) disable iff (!resetn)
      (polarity && !trig_select[0] && output_level_register[0]) |=> !out_gate[0];
  endproperty
  a_pol_off: assert property (p_pol_off) else $error("polarity did not turn output off");

  property p_comb_sel;
    @(posedge clk) disable iff (!resetn)
      trig_select[COMBINED_BIT] |=> (out_gate[COMBINED_BIT] == $past(trig_event[COMBINED_BIT]));
  endproperty
  a_comb_sel: assert property (p_comb_sel) else $error("bit four not combined trigger");

  property p_chan_sel;
    @(posedge clk) disable iff (!resetn)
      trig_select[1] |=> (out_gate[1] == $past(chan_level[1]));
  endproperty
  a_chan_sel: assert property (p_chan_sel) else $error("bit one not channel trigger");

  property p_trig_on;
    @(posedge clk) disable iff (!resetn)
      (trig_select[0] && trig_event[0] && !width_code[2] && trig_select == $past(trig_select)) |=> ##1 out_gate[0];
  endproperty
  a_trig_on: assert property (p_trig_on) else $error("trigger did not turn output on");

  sequence s_cfg_write;
    write_fire && aw_addr == OFF_CONFIG && w_strb[3];
  endsequence
  property p_width_wr;
    @(posedge clk) disable iff (!resetn)
      s_cfg_write |=> (width_code == $past(w_data[CFG_WIDTH_MSB:CFG_WIDTH_LSB]));
  endproperty
  a_width_wr: assert property (p_width_wr) else $error("width field not stored");

  property p_sel_wr;
    @(posedge clk) disable iff (!resetn)
      (write_fire && aw_addr == OFF_CONFIG && w_strb[0]) |=> (trig_select == $past(w_data[NUM_TRIG-1:0]));
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("select bits not stored");

endmodule : digital_output_trigger_port

// >>> test/output_load_model.sv
`timescale 1ns/100ps
module output_load_model
  import trig_port_pkg::*;
(
  input  wire logic [NUM_OUT-1:0] gate_on,
  output logic [NUM_OUT-1:0]      line_level
);
  // ----------------------------------------------------------------
  // load lines
  // ----------------------------------------------------------------
  // off means pulled
  // an off transistor leaves the line to its pull-up, never a stale level
  assign line_level = ~gate_on;
endmodule : output_load_model

// >>> test/test_digital_output_trigger_port.sv
`timescale 1ns/100ps
module test_digital_output_trigger_port;
  import trig_port_pkg::*;

  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic [ADDR_W-1:0]   awaddr = '0;
  logic                awvalid = 1'b0;
  logic                awready;
  logic [31:0]         wdata = '0;
  logic [3:0]          wstrb = 4'h0;
  logic                wvalid = 1'b0;
  logic                wready;
  logic [1:0]          bresp;
  logic                bvalid;
  logic                bready = 1'b0;
  logic [ADDR_W-1:0]   araddr = '0;
  logic                arvalid = 1'b0;
  logic                arready;
  logic [31:0]         rdata;
  logic [1:0]          rresp;
  logic                rvalid;
  logic                rready = 1'b0;
  logic [NUM_TRIG-1:0] trig_event = '0;
  logic [NUM_OUT-1:0]  out_gate;
  logic [NUM_OUT-1:0]  line_level;
  logic [1:0]          resp;
  logic [31:0]         rd;
  int                  fails = 0;
  int                  n_checks = 0;
  int                  cycles = 0;

  always #4 clk = ~clk;

  digital_output_trigger_port i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trig_event(trig_event), .out_gate(out_gate));

  output_load_model i_load (.gate_on(out_gate), .line_level(line_level));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr  <= addr;
    awvalid <= 1'b1;
    wdata   <= data;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] addr, output logic [31:0] data, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        data = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
  endtask : axi_read

  // ----------------------------------------------------------------
  // compare tasks
  // ----------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_range(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_range

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic fire(input logic [4:0] mask);
    @(posedge clk);
    trig_event <= mask;
    @(posedge clk);
    trig_event <= 5'h00;
  endtask : fire

  // pulse length counted in cycles from the first high sample; capped to bound long codes
  task automatic pulse_test(input logic [2:0] code, input int n_us, input int cap);
    int len;
    int lo;
    int hi;
    len = 0;
    lo = n_us * TICK_CYCLES - 4;
    hi = (n_us + 1) * TICK_CYCLES;
    if (lo > cap) lo = cap;
    if (hi > cap) hi = cap;
    axi_write(OFF_CONFIG, {code, 24'h00_0000, 5'h0f}, resp);
    fire(5'h0f);
    settle(2);
    check_val({24'h00_0000, out_gate}, 32'h0000_00ef);
    while (out_gate[0] === 1'b1 && len < cap) begin
      settle(1);
      len++;
    end
    check_range(len, lo, hi);
  endtask : pulse_test

  task automatic finish_test();
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    // whole run needs about 60000 cycles; the 1 ms pulse is only measured up to its cap
    if (cycles == 80000) begin
      fails++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic exp_t;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    settle(1);
    check_val({24'h00_0000, out_gate}, 32'h0000_0000);
    axi_read(OFF_CONFIG, rd, resp);
    check_val(rd, 32'h0000_0000);
    check_val({30'h0000_0000, resp}, {30'h0000_0000, RESP_OKAY});
    axi_write(OFF_CONFIG, 32'hffff_ffff, resp);
    check_val({30'h0000_0000, resp}, {30'h0000_0000, RESP_OKAY});
    axi_read(OFF_CONFIG, rd, resp);
    check_val(rd, 32'he000_003f);
    axi_write(OFF_CONFIG, 32'h0000_0020, resp);
    axi_write(OFF_LEVELS, 32'hffff_ffa5, resp);
    settle(2);
    check_val({24'h00_0000, out_gate}, 32'h0000_005a);
    check_val({24'h00_0000, line_level}, 32'h0000_00a5);
    axi_read(OFF_LEVELS, rd, resp);
    check_val(rd, 32'h0000_00a5);
    axi_write(OFF_CONFIG, 32'h0000_0000, resp);
    settle(2);
    check_val({24'h00_0000, out_gate}, 32'h0000_00a5);
    axi_write(4'h8, 32'h1234_5678, resp);
    check_val({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
    axi_read(4'h8, rd, resp);
    check_val(rd, 32'h0000_0000);
    check_val({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
    axi_write(OFF_LEVELS, 32'h0000_00e0, resp);
    axi_write(OFF_CONFIG, 32'h0000_0010, resp);
    // only the combined trigger here: a channel event would start a 1 ms pulse
    // that the toggle test below would then inherit as its starting level
    @(posedge clk);
    trig_event <= 5'h10;
    settle(3);
    check_val({24'h00_0000, out_gate}, 32'h0000_00f0);
    @(posedge clk);
    trig_event <= 5'h00;
    settle(3);
    check_val({24'h00_0000, out_gate}, 32'h0000_00e0);
    exp_t = 1'b0;
    for (int c = 4; c < 8; c++) begin
      axi_write(OFF_CONFIG, {c[2:0], 29'h0000_0001}, resp);
      fire(5'h01);
      settle(3);
      exp_t = ~exp_t;
      check_val({31'h0000_0000, out_gate[0]}, {31'h0000_0000, exp_t});
    end
    pulse_test(3'h3, PW_CODE3_US, 5000);
    pulse_test(3'h2, PW_CODE2_US, 5000);
    pulse_test(3'h1, PW_CODE1_US, 30000);
    pulse_test(3'h0, PW_CODE0_US, 30000);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    settle(1);
    check_val({24'h00_0000, out_gate}, 32'h0000_0000);
    axi_read(OFF_LEVELS, rd, resp);
    check_val(rd, 32'h0000_0000);
    finish_test();
  end
endmodule : test_digital_output_trigger_port
